// *** hdl/csfb_alu.sv ***
// ALU slice producing result and zero, nibble-carry and carry flags.
// Assumes a purely combinational use by the flag bank top.
`timescale 1ns/1ns
module csfb_alu (
    // Instruction in
    input wire csfb_pkg::csfb_instr_s instr,
    // Answer out
    output csfb_pkg::csfb_alu_s alu
);

    // ----------------------------------------------------------------
    // Adder: subtraction adds the two's complement of the second operand
    // ----------------------------------------------------------------
    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_cin;
    logic is_sub;
    logic [8:0] sum;
    logic [4:0] low_sum;
    logic [7:0] logic_res;

    assign is_sub = (instr.op == csfb_pkg::OP_FILE_MINUS_W) || (instr.op == csfb_pkg::OP_LITERAL_MINUS_W);
    assign add_a = instr.file_val;
    assign add_b = is_sub ? ~instr.w_val : instr.w_val;
    assign add_cin = is_sub;
    assign sum = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
    assign low_sum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};

    always_comb begin
        logic_res = 8'h00;
        case (instr.op)
            csfb_pkg::OP_AND: logic_res = instr.file_val & instr.w_val;
            csfb_pkg::OP_MOVE_W_TO_FILE: logic_res = instr.w_val;
            csfb_pkg::OP_BIT_CLEAR: logic_res = instr.file_val & ~(8'h01 << instr.bit_sel);
            csfb_pkg::OP_BIT_SET: logic_res = instr.file_val | (8'h01 << instr.bit_sel);
            csfb_pkg::OP_NIBBLE_SWAP: logic_res = {instr.file_val[3:0], instr.file_val[7:4]};
            default: logic_res = 8'h00;
        endcase
    end

    assign alu.sets_carries = (instr.op == csfb_pkg::OP_ADD) || is_sub;
    assign alu.sets_zero = alu.sets_carries || (instr.op == csfb_pkg::OP_AND)
        || (instr.op == csfb_pkg::OP_FILE_ZEROING);
    assign alu.result = alu.sets_carries ? sum[7:0] : logic_res;
    assign alu.zero = (alu.result == 8'h00);
    assign alu.nibble_carry = low_sum[4];
    assign alu.carry = sum[8];

endmodule

// *** hdl/csfb_bank_map.sv ***
// Bank offset decoder: splits a 7-bit offset into its region and RAM index.
// Assumes the caller supplies the selected bank, not a linear index.
`timescale 1ns/1ns
module csfb_bank_map #(
    parameter int BANKS = csfb_pkg::BANK_COUNT
) (
    // Banked address in
    input wire logic [1:0] bank,
    input wire logic [6:0] offset,
    // Decode out
    output csfb_pkg::csfb_region_e region,
    output logic [8:0] gram_index,
    output logic [3:0] common_index
);

    logic [6:0] gram_off;

    assign region = (offset <= csfb_pkg::CORE_LAST) ? csfb_pkg::REGION_CORE :
        (offset <= csfb_pkg::PERIPH_LAST) ? csfb_pkg::REGION_PERIPH :
        (offset <= csfb_pkg::GRAM_LAST) ? csfb_pkg::REGION_GRAM : csfb_pkg::REGION_COMMON;
    assign gram_off = offset - csfb_pkg::GRAM_FIRST;
    assign gram_index = 9'(bank * csfb_pkg::GRAM_BYTES) + {2'b00, gram_off};
    // Common bytes ignore the bank entirely
    assign common_index = offset[3:0];

endmodule

// *** hdl/csfb_pkg.sv ***
// Package for the core flags and bank map block: register offsets, bit positions,
// reset values, bank partition bounds and the carrier structs.
// Assumes nothing of its surroundings; every user names items as csfb_pkg::name.
package csfb_pkg;

    // ----------------------------------------------------------------
    // Flag bit positions in core_flags
    // ----------------------------------------------------------------
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_SLEEP_N = 3;
    localparam int FLAG_WDOG_N = 4;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h1F;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] CAUSE_RESET = 2'h3;
    localparam logic [2:0] ARITH_RESET = 3'h0;

    // ----------------------------------------------------------------
    // Bank partition (7-bit bank offset)
    // ----------------------------------------------------------------
    localparam logic [6:0] CORE_FIRST = 7'h00;
    localparam logic [6:0] CORE_LAST = 7'h0B;
    localparam logic [6:0] PERIPH_FIRST = 7'h0C;
    localparam logic [6:0] PERIPH_LAST = 7'h1F;
    localparam logic [6:0] GRAM_FIRST = 7'h20;
    localparam logic [6:0] GRAM_LAST = 7'h6F;
    localparam logic [6:0] COMMON_FIRST = 7'h70;
    localparam int GRAM_BYTES = 80;
    localparam int COMMON_BYTES = 16;
    localparam int BANK_COUNT = 4;

    // ----------------------------------------------------------------
    // APB register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] REG_CORE_FLAGS = 12'h000;
    localparam logic [11:0] REG_BANK_SEL = 12'h004;
    localparam logic [11:0] REG_POINTER = 12'h008;
    localparam logic [11:0] REG_INDIRECT = 12'h00C;
    localparam logic [11:0] REG_DATA_BASE = 12'h200;
    localparam logic [11:0] REG_DATA_LAST = 12'h3FC;
    localparam logic [11:0] REG_OP = 12'h010;
    localparam logic [11:0] REG_OPERANDS = 12'h014;
    localparam logic [11:0] REG_EVENTS = 12'h018;
    localparam logic [11:0] REG_RESULT = 12'h01C;

    // Operation codes written to REG_OP
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD = 4'h1,
        OP_FILE_MINUS_W = 4'h2,
        OP_LITERAL_MINUS_W = 4'h3,
        OP_AND = 4'h4,
        OP_FILE_ZEROING = 4'h5,
        OP_MOVE_W_TO_FILE = 4'h6,
        OP_BIT_CLEAR = 4'h7,
        OP_BIT_SET = 4'h8,
        OP_NIBBLE_SWAP = 4'h9
    } csfb_op_e;

    // Region of a bank offset
    typedef enum logic [1:0] {
        REGION_CORE = 2'h0,
        REGION_PERIPH = 2'h1,
        REGION_GRAM = 2'h2,
        REGION_COMMON = 2'h3
    } csfb_region_e;

    // One instruction handed to the flag unit
    typedef struct packed {
        logic valid;
        csfb_op_e op;
        logic [7:0] file_val;
        logic [7:0] w_val;
        logic [2:0] bit_sel;
        logic to_flags;
    } csfb_instr_s;

    // ALU answer
    typedef struct packed {
        logic [7:0] result;
        logic zero;
        logic nibble_carry;
        logic carry;
        logic sets_zero;
        logic sets_carries;
    } csfb_alu_s;

    // APB request
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } csfb_apb_req_s;

endpackage

// *** hdl/csfb_top.sv ***
// Core flags register and banked data memory map, reached over APB.
// Assumes one 10 MHz clock, APB master on the same clock, watchdog and sleep
// events as one-cycle pulses, and a power-on/brown-out reset on rst_b.
//
// Behaviour
// - Status register accepts any instruction destination
// - Flag-updating ops override written flag bits
// - Reset-cause flags ignore all instruction writes
// - File zeroing clears all eight result bits, sets zero
// - Subtraction carries act as inverted borrows
// - Bits seven to five read zero
// - Watchdog flag: set restart/sleep/power, clear timeout
// - Sleep flag: set power/restart, clear on sleep
// - Zero flag follows zero result
// - Nibble carry from bit three carry
// - Carry from most significant bit
// - Power reset: causes one, arithmetic zero
// - Offsets 0Ch to 1Fh are peripheral registers
// - Up to 80 general RAM bytes per bank
// - General RAM linearly reachable through pointer
// - Sixteen common bytes shared by all banks
// - Seven-bit offset with four fixed regions
`timescale 1ns/1ns
module csfb_top #(
    parameter int BANKS = csfb_pkg::BANK_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Other resets: reload cause flags by condition, keep arithmetic flags
    input wire logic other_reset,
    input wire logic other_reset_wdog_n,
    input wire logic other_reset_sleep_n,
    // Hardware events
    input wire logic watchdog_timeout,
    input wire logic sleep_op,
    input wire logic watchdog_restart_op,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flag view
    output logic [7:0] core_flags_out
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_sync1_b;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync1_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_sync1_b <= 1'b1;
            rst_sync_b <= rst_sync1_b;
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic watchdog_expired_n;
    logic sleep_entered_n;
    logic zero;
    logic nibble_carry;
    logic carry;
    logic [1:0] bank_sel;
    logic [8:0] indirect_pointer;
    logic [7:0] w_reg;
    logic [7:0] file_reg;
    logic [2:0] bit_reg;
    logic [7:0] result_reg;
    logic [7:0] general_ram [BANKS*csfb_pkg::GRAM_BYTES];
    logic [7:0] common_ram [csfb_pkg::COMMON_BYTES];

    logic [7:0] flags_view;
    assign flags_view = {3'b000, watchdog_expired_n, sleep_entered_n, zero, nibble_carry, carry};

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic acc_wr;
    logic acc_rd;
    logic hit_flags;
    logic hit_bank;
    logic hit_ptr;
    logic hit_ind;
    logic hit_op;
    logic hit_opnd;
    logic hit_ev;
    logic hit_res;
    logic hit_data;
    logic mapped;

    assign acc_wr = psel && penable && pwrite;
    assign acc_rd = psel && !pwrite;
    assign hit_flags = paddr == csfb_pkg::REG_CORE_FLAGS;
    assign hit_bank = paddr == csfb_pkg::REG_BANK_SEL;
    assign hit_ptr = paddr == csfb_pkg::REG_POINTER;
    assign hit_ind = paddr == csfb_pkg::REG_INDIRECT;
    assign hit_op = paddr == csfb_pkg::REG_OP;
    assign hit_opnd = paddr == csfb_pkg::REG_OPERANDS;
    assign hit_ev = paddr == csfb_pkg::REG_EVENTS;
    assign hit_res = paddr == csfb_pkg::REG_RESULT;
    assign hit_data = (paddr >= csfb_pkg::REG_DATA_BASE) && (paddr <= csfb_pkg::REG_DATA_LAST)
        && (paddr[1:0] == 2'b00);
    assign mapped = hit_flags || hit_bank || hit_ptr || hit_ind || hit_op || hit_opnd || hit_ev
        || hit_res || hit_data;

    // ----------------------------------------------------------------
    // Banked window: data word n is bank offset n in the selected bank
    // ----------------------------------------------------------------
    csfb_pkg::csfb_region_e region;
    logic [8:0] gram_index;
    logic [3:0] common_index;
    logic [6:0] bank_offset;

    assign bank_offset = paddr[8:2];

    csfb_bank_map #(.BANKS(BANKS)) u_map (
        .bank(bank_sel),
        .offset(bank_offset),
        .region(region),
        .gram_index(gram_index),
        .common_index(common_index)
    );

    // Linear pointer reaches general RAM without bank selection
    logic ptr_ok;
    assign ptr_ok = indirect_pointer < 9'(BANKS * csfb_pkg::GRAM_BYTES);

    // Core offset 03h is the flag register inside every bank
    logic data_is_flags;
    assign data_is_flags = hit_data && (region == csfb_pkg::REGION_CORE) && (bank_offset == 7'h03);

    // ----------------------------------------------------------------
    // Instruction executed on the flag register
    // ----------------------------------------------------------------
    csfb_pkg::csfb_instr_s instr;
    csfb_pkg::csfb_alu_s alu;
    logic op_go;

    assign op_go = acc_wr && hit_op;
    assign instr.valid = op_go;
    assign instr.op = csfb_pkg::csfb_op_e'(pwdata[3:0]);
    assign instr.to_flags = pwdata[8];
    assign instr.bit_sel = bit_reg;
    assign instr.w_val = w_reg;
    assign instr.file_val = pwdata[8] ? flags_view : file_reg;

    csfb_alu u_alu (
        .instr(instr),
        .alu(alu)
    );

    // Plain data write to flags: only arithmetic bits, upper bits dropped
    logic plain_wr;
    logic op_to_flags;
    logic [7:0] next_arith_src;
    assign plain_wr = acc_wr && (hit_flags || data_is_flags);
    // File zeroing on the flag register only sets zero; carries keep their value
    assign op_to_flags = op_go && instr.to_flags && (instr.op != csfb_pkg::OP_FILE_ZEROING);
    assign next_arith_src = plain_wr ? pwdata[7:0] : alu.result;

    logic next_zero;
    logic next_nibble;
    logic next_carry;

    // Flag-setting op wins over its own data write to the same bits
    assign next_zero = (op_go && alu.sets_zero) ? alu.zero :
        (plain_wr || op_to_flags) ? next_arith_src[csfb_pkg::FLAG_ZERO] : zero;
    assign next_nibble = (op_go && alu.sets_carries) ? alu.nibble_carry :
        (plain_wr || op_to_flags) ? next_arith_src[csfb_pkg::FLAG_NIBBLE] : nibble_carry;
    assign next_carry = (op_go && alu.sets_carries) ? alu.carry :
        (plain_wr || op_to_flags) ? next_arith_src[csfb_pkg::FLAG_CARRY] : carry;

    // Software may raise events through REG_EVENTS as well as the pins
    logic ev_timeout;
    logic ev_sleep;
    logic ev_restart;
    assign ev_timeout = watchdog_timeout || (acc_wr && hit_ev && pwdata[0]);
    assign ev_sleep = sleep_op || (acc_wr && hit_ev && pwdata[1]);
    assign ev_restart = watchdog_restart_op || (acc_wr && hit_ev && pwdata[2]);

    // Timeout is the stronger event: it marks the cause even during sleep
    logic next_wdog_n;
    logic next_sleep_n;
    assign next_wdog_n = other_reset ? other_reset_wdog_n :
        ev_timeout ? 1'b0 : (ev_restart || ev_sleep) ? 1'b1 : watchdog_expired_n;
    assign next_sleep_n = other_reset ? other_reset_sleep_n :
        ev_sleep ? 1'b0 : ev_restart ? 1'b1 : sleep_entered_n;

    // ----------------------------------------------------------------
    // Flag registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            {watchdog_expired_n, sleep_entered_n} <= csfb_pkg::CAUSE_RESET;
            {zero, nibble_carry, carry} <= csfb_pkg::ARITH_RESET;
        end else begin
            watchdog_expired_n <= next_wdog_n;
            sleep_entered_n <= next_sleep_n;
            zero <= next_zero;
            nibble_carry <= next_nibble;
            carry <= next_carry;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            bank_sel <= 2'h0;
            indirect_pointer <= 9'h000;
            w_reg <= 8'h00;
            file_reg <= 8'h00;
            bit_reg <= 3'h0;
            result_reg <= 8'h00;
        end else begin
            if (acc_wr && hit_bank) begin
                bank_sel <= pwdata[1:0];
            end
            if (acc_wr && hit_ptr) begin
                indirect_pointer <= pwdata[8:0];
            end
            if (acc_wr && hit_opnd) begin
                w_reg <= pwdata[7:0];
                file_reg <= pwdata[15:8];
                bit_reg <= pwdata[18:16];
            end
            if (op_go) begin
                result_reg <= alu.result;
            end
        end
    end

    // ----------------------------------------------------------------
    // RAM storage, no reset
    // ----------------------------------------------------------------
    logic gram_wr;
    logic ind_wr;
    logic common_wr;
    assign gram_wr = acc_wr && hit_data && (region == csfb_pkg::REGION_GRAM)
        && (gram_index < 9'(BANKS * csfb_pkg::GRAM_BYTES));
    assign ind_wr = acc_wr && hit_ind && ptr_ok;
    assign common_wr = acc_wr && hit_data && (region == csfb_pkg::REGION_COMMON);

    always_ff @(posedge clk) begin
        if (gram_wr) begin
            general_ram[gram_index] <= pwdata[7:0];
        end else if (ind_wr) begin
            general_ram[indirect_pointer] <= pwdata[7:0];
        end
        if (common_wr) begin
            common_ram[common_index] <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    logic [7:0] data_rd;
    logic [31:0] next_prdata;

    always_comb begin
        data_rd = 8'h00;
        case (region)
            csfb_pkg::REGION_GRAM: data_rd = (gram_index < 9'(BANKS * csfb_pkg::GRAM_BYTES))
                ? general_ram[gram_index] : 8'h00;
            csfb_pkg::REGION_COMMON: data_rd = common_ram[common_index];
            csfb_pkg::REGION_CORE: data_rd = (bank_offset == 7'h03) ? flags_view : 8'h00;
            default: data_rd = 8'h00; // Peripheral registers live outside this block
        endcase
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_flags) begin
            next_prdata = {24'h000000, flags_view};
        end else if (hit_bank) begin
            next_prdata = {30'h0, bank_sel};
        end else if (hit_ptr) begin
            next_prdata = {23'h0, indirect_pointer};
        end else if (hit_ind) begin
            next_prdata = {24'h0, ptr_ok ? general_ram[indirect_pointer] : 8'h00};
        end else if (hit_opnd) begin
            next_prdata = {13'h0, bit_reg, file_reg, w_reg};
        end else if (hit_res) begin
            next_prdata = {24'h0, result_reg};
        end else if (hit_data) begin
            next_prdata = {24'h0, data_rd};
        end
    end

    // ----------------------------------------------------------------
    // APB answer: one wait-free access phase
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            core_flags_out <= 8'h00;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (acc_rd && !penable) ? next_prdata : 32'h0000_0000;
            core_flags_out <= {3'b000, next_wdog_n, next_sleep_n, next_zero, next_nibble, next_carry};
        end
    end

endmodule

// *** tb/core_status_flags_bank_map_tb.sv ***
// Self-checking bench for csfb_top: APB master, event pins, integer flag model.
// Assumes the bound checker and one 10 MHz clock.
`timescale 1ns/1ns
module core_status_flags_bank_map_tb;
    logic clk, rst_b, other_reset, other_reset_wdog_n, other_reset_sleep_n;
    logic watchdog_timeout, sleep_op, watchdog_restart_op, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, e;
    logic [7:0] core_flags_out;
    int errors, num_checks, wd, sl, z, dc, c, f, w, b, op, dst, r;
    csfb_top u_csfb_top (.clk(clk), .rst_b(rst_b), .other_reset(other_reset),
        .other_reset_wdog_n(other_reset_wdog_n), .other_reset_sleep_n(other_reset_sleep_n),
        .watchdog_timeout(watchdog_timeout), .sleep_op(sleep_op), .watchdog_restart_op(watchdog_restart_op),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_flags_out(core_flags_out));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task summarize();
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is sampled high, bounded
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            errors++;
            summarize();
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    function logic [31:0] fl();
        return {27'h0, wd[0], sl[0], z[0], dc[0], c[0]};
    endfunction
    initial begin
        {rst_b, other_reset, other_reset_wdog_n, other_reset_sleep_n, psel, penable, pwrite} = '0;
        {watchdog_timeout, sleep_op, watchdog_restart_op, paddr, pwdata} = '0;
        errors = 0;
        num_checks = 0;
        {wd, sl, z, dc, c} = {32'd1, 32'd1, 96'd0};
        void'($urandom(89019));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        rd(csfb_pkg::REG_CORE_FLAGS, fl());
        apb(1'b1, csfb_pkg::REG_CORE_FLAGS, 32'hFF);
        {z, dc, c} = {32'd1, 32'd1, 32'd1};
        rd(csfb_pkg::REG_CORE_FLAGS, fl());
        apb(1'b1, csfb_pkg::REG_DATA_BASE + 12'h00C, 32'h0);
        {z, dc, c} = {32'd0, 32'd0, 32'd0};
        rd(csfb_pkg::REG_CORE_FLAGS, fl());
        for (int k = 0; k < 45; k++) begin
            op = k % 9 + 1;
            f = $urandom % 256;
            w = $urandom % 256;
            b = $urandom % 8;
            dst = $urandom % 2;
            if (dst == 1) f = fl();
            case (op)
                1: r = f + w;
                2, 3: r = f + (~w & 255) + 1;
                4: r = f & w;
                5: r = 0;
                6: r = w;
                7: r = f & ~(1 << b);
                8: r = f | (1 << b);
                default: r = ((f & 15) << 4) | (f >> 4);
            endcase
            if (op <= 3) begin
                c = r > 255;
                dc = ((f & 15) + (op == 1 ? w & 15 : (~w & 15) + 1)) > 15;
            end else if (dst == 1 && op != 5) begin
                c = r & 1;
                dc = (r >> 1) & 1;
            end
            r = r & 255;
            if (op <= 5) z = r == 0;
            else if (dst == 1) z = (r >> 2) & 1;
            apb(1'b1, csfb_pkg::REG_OPERANDS, (b << 16) | (f << 8) | w);
            apb(1'b1, csfb_pkg::REG_OP, (dst << 8) | op);
            rd(csfb_pkg::REG_RESULT, r);
            rd(csfb_pkg::REG_CORE_FLAGS, fl());
        end
        for (int k = 0; k < 16; k++) begin
            if (k < 8) begin
                @(posedge clk);
                {watchdog_restart_op, sleep_op, watchdog_timeout} <= k[2:0];
                @(posedge clk);
                {watchdog_restart_op, sleep_op, watchdog_timeout} <= 3'h0;
            end else begin
                apb(1'b1, csfb_pkg::REG_EVENTS, k & 7);
            end
            if (k & 1) wd = 0;
            else if (k & 6) wd = 1;
            if (k & 2) sl = 0;
            else if (k & 4) sl = 1;
            rd(csfb_pkg::REG_CORE_FLAGS, fl());
        end
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {other_reset, other_reset_wdog_n, other_reset_sleep_n} <= {1'b1, k[1:0]};
            @(posedge clk);
            other_reset <= 1'b0;
            wd = k >> 1;
            sl = k & 1;
            rd(csfb_pkg::REG_CORE_FLAGS, fl());
        end
        for (int k = 0; k < 4; k++) begin
            f = 32 + $urandom % 80;
            w = $urandom % 256;
            apb(1'b1, csfb_pkg::REG_BANK_SEL, k);
            apb(1'b1, csfb_pkg::REG_DATA_BASE + 12'(4 * f), w);
            apb(1'b1, csfb_pkg::REG_DATA_BASE + 12'(4 * (112 + k)), 8'hA0 + k);
            apb(1'b1, csfb_pkg::REG_DATA_BASE + 12'(4 * (12 + k * 6)), 32'h5A);
            rd(csfb_pkg::REG_DATA_BASE + 12'(4 * (12 + k * 6)), 32'h0);
            apb(1'b1, csfb_pkg::REG_POINTER, k * 80 + f - 32);
            rd(csfb_pkg::REG_INDIRECT, w);
            rd(csfb_pkg::REG_DATA_BASE + 12'(4 * f), w);
        end
        for (int k = 0; k < 4; k++) begin
            rd(csfb_pkg::REG_DATA_BASE + 12'(4 * (112 + k)), 8'hA0 + k);
        end
        apb(1'b1, csfb_pkg::REG_POINTER, 4 * 80);
        rd(csfb_pkg::REG_INDIRECT, 32'h0);
        rd(12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        summarize();
    end
endmodule

// *** tb/csfb_chk.sv ***
// Port-level checker for csfb_top: APB timing and flag event rules.
// Assumes one clock domain; bound into csfb_top below.
`timescale 1ns/1ns
module csfb_chk (
    // Clock, reset, events
    input wire logic clk,
    input wire logic rst_b,
    input wire logic other_reset,
    input wire logic other_reset_wdog_n,
    input wire logic other_reset_sleep_n,
    input wire logic watchdog_timeout,
    input wire logic sleep_op,
    input wire logic watchdog_restart_op,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Flag view
    input wire logic [7:0] core_flags_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Reset runs through a synchronizer, so flags settle a few edges late
    logic [3:0] up;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) up <= 4'h0;
        else up <= {up[2:0], 1'b1};
    end
    wire run = up[3];
    wire acc = psel && penable;
    wire quiet = !(other_reset || watchdog_timeout || sleep_op || watchdog_restart_op);
    wire ev_wr = acc && pwrite && paddr == csfb_pkg::REG_EVENTS;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence answer_s;
        pready ##1 !pready;
    endsequence
    a_apb_answer: assert property (setup_s |=> answer_s) else $error("pready not one cycle");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
    a_top_zero: assert property (core_flags_out[7:5] == 3'h0) else $error("top bits set");
    a_timeout_clr: assert property (run && watchdog_timeout && !other_reset |=> !core_flags_out[4])
        else $error("timeout kept flag");
    a_sleep_clr: assert property (run && sleep_op && !watchdog_timeout && !other_reset
        |=> core_flags_out[4:3] == 2'h2) else $error("sleep flags wrong");
    a_restart_set: assert property (run && watchdog_restart_op && !sleep_op && !watchdog_timeout
        && !other_reset |=> core_flags_out[4:3] == 2'h3) else $error("restart flags wrong");
    a_cause_hold: assert property (run && quiet && !ev_wr |=> $stable(core_flags_out[4:3]))
        else $error("cause flag written");
    a_other_load: assert property (run && other_reset && !acc |=> core_flags_out[4:0] ==
        {$past(other_reset_wdog_n), $past(other_reset_sleep_n), $past(core_flags_out[2:0])})
        else $error("other reset load wrong");
    a_post_reset: assert property ($rose(run) |-> core_flags_out == 8'h18) else $error("reset value");
endmodule

bind csfb_top csfb_chk u_csfb_chk (.clk(clk), .rst_b(rst_b), .other_reset(other_reset),
    .other_reset_wdog_n(other_reset_wdog_n), .other_reset_sleep_n(other_reset_sleep_n),
    .watchdog_timeout(watchdog_timeout), .sleep_op(sleep_op), .watchdog_restart_op(watchdog_restart_op),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_flags_out(core_flags_out));
